// ---- design/wsd_core.sv ----
`timescale 1ns/1ps
module wsd_core
  import wsd_pkg::*;
#(
  parameter int STILL_COUNT = STILL_CYC,
  parameter int NCH = 4
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] cmp_i,
  input wire logic count_gate_pin_i,
  input wire logic count_clear_pin_i,
  input wire logic [1:0] od_short_i,
  input wire logic [1:0] od_oc_i,
  input wire logic sensor_type_i,
  input wire logic diag_en_i,
  input wire logic [1:0] counter_input_select_i,
  input wire logic [1:0] od_enable_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  output logic [7:0] reg_rdata_o,
  output logic [NCH-1:0] speed_pulse_out_o,
  output logic [1:0] speed_open_drain_out_o,
  output logic [1:0] speed_open_drain_oe_o,
  output logic [NCH-1:0] overcurrent_o,
  output logic [NCH-1:0] undercurrent_o
);

  localparam int SW = $clog2(STILL_COUNT + 1);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wsd_pins_t pins_w;
  wsd_pins_t sync1_r;
  wsd_pins_t sync2_r;

  assign pins_w = '{cmp: cmp_i, gate: count_gate_pin_i,
                    clr: count_clear_pin_i, od_short: od_short_i,
                    od_oc: od_oc_i};

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pins_w;
      sync2_r <= sync1_r;
    end
  end

  wire active_w = sensor_type_i != SENSOR_INTELLIGENT;
  wire rd_fault_w = reg_rd_i && (reg_addr_i == REG_OD_FAULT);
  wire rd_cflag_w = reg_rd_i && (reg_addr_i == REG_CNT_FLAGS);
  wire rd_new_w = reg_rd_i && (reg_addr_i == REG_NEW_FRAME);
  wire rd_still_w = reg_rd_i && (reg_addr_i == REG_STANDSTILL);

  // ----------------------------------------------------------------
  // per-channel classification and diagnostics
  // ----------------------------------------------------------------
  wsd_class_t cls_w [NCH];
  logic [NCH-1:0] pulse_r;
  logic [NCH-1:0] over_r;
  logic [NCH-1:0] under_r;
  logic [NCH-1:0] new_frame_flag_r;
  logic [NCH-1:0] standstill_flag_r;
  logic [8:0] diag_word_bits_w [NCH];
  logic [3:0] valid_bit_tally_w [NCH];

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    wire [3:0] lv_w = sync2_r.cmp[4*g +: 4];
    logic frame_w;
    logic prev_pulse_r;
    logic [SW-1:0] still_r;
    wire still_hit_w = still_r == SW'(STILL_COUNT);

    assign cls_w[g].over = active_w ? lv_w[2] : lv_w[3];
    assign cls_w[g].high = active_w ? (lv_w[1] && !lv_w[2])
                                    : (lv_w[2] && !lv_w[3]);
    assign cls_w[g].diag = !active_w && lv_w[1] && !lv_w[2];
    assign cls_w[g].under = !lv_w[0];

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        pulse_r[g] <= 1'b0;
        over_r[g] <= 1'b0;
        under_r[g] <= 1'b0;
        prev_pulse_r <= 1'b0;
        still_r <= '0;
        new_frame_flag_r[g] <= 1'b0;
        standstill_flag_r[g] <= 1'b0;
      end else begin
        pulse_r[g] <= active_w ? lv_w[1] : lv_w[2];
        over_r[g] <= cls_w[g].over;
        under_r[g] <= cls_w[g].under;
        prev_pulse_r <= pulse_r[g];
        // idle time since the last speed edge
        if (pulse_r[g] != prev_pulse_r) begin
          still_r <= '0;
        end else if (!still_hit_w) begin
          still_r <= still_r + SW'(1);
        end
        new_frame_flag_r[g] <= frame_w ||
                               (new_frame_flag_r[g] && !rd_new_w);
        standstill_flag_r[g] <= (frame_w && still_hit_w) ||
                                (standstill_flag_r[g] && !rd_still_w);
      end
    end

    wsd_manchester u_dec (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .en_i(diag_en_i && !active_w),
      .level_i(cls_w[g].diag),
      .word_o(diag_word_bits_w[g]),
      .tally_o(valid_bit_tally_w[g]),
      .frame_o(frame_w)
    );
  end

  assign speed_pulse_out_o = pulse_r;
  assign overcurrent_o = over_r;
  assign undercurrent_o = under_r;

  // ----------------------------------------------------------------
  // open-drain speed outputs
  // ----------------------------------------------------------------
  logic [1:0] od_short_flag_r;
  logic [1:0] od_overcurrent_flag_r;
  logic [1:0] od_oe_r;

  for (genvar j = 0; j < 2; j++) begin : g_od
    logic [OD_DELAY_CYC-1:0] dly_r;
    logic [TMR_W-1:0] hold_r;
    logic off_r;
    wire oc_w = sync2_r.od_oc[j];
    wire hold_done_w = hold_r == TMR_W'(OD_HOLD_CYC);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        dly_r <= '0;
        hold_r <= '0;
        off_r <= 1'b0;
        od_oe_r[j] <= 1'b0;
        od_short_flag_r[j] <= 1'b0;
        od_overcurrent_flag_r[j] <= 1'b0;
      end else begin
        // fixed delay, pull low on high
        dly_r <= {dly_r[OD_DELAY_CYC-2:0], pulse_r[j]};
        od_oe_r[j] <= dly_r[OD_DELAY_CYC-1] && od_enable_i[j] && !off_r;
        if (!oc_w) begin
          hold_r <= '0;
        end else if (!hold_done_w) begin
          hold_r <= hold_r + TMR_W'(1);
        end
        // enable bit untouched; only a write of 0 re-arms
        if (!od_enable_i[j]) begin
          off_r <= 1'b0;
        end else if (oc_w && hold_done_w) begin
          off_r <= 1'b1;
        end
        // sticky until read with cause gone
        od_short_flag_r[j] <= sync2_r.od_short[j] ||
                              (od_short_flag_r[j] && !rd_fault_w);
        od_overcurrent_flag_r[j] <= oc_w ||
                              (od_overcurrent_flag_r[j] && !rd_fault_w);
      end
    end
  end

  // open drain only ever drives low
  assign speed_open_drain_out_o = 2'b00;
  assign speed_open_drain_oe_o = od_oe_r;

  // ----------------------------------------------------------------
  // edge counter
  // ----------------------------------------------------------------
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic sel_prev_r;
  logic count_overflow_flag_r;
  logic count_conflict_flag_r;
  logic sel_pulse_w;

  // bit 0 picks the upper pair
  always_comb begin
    unique case (counter_input_select_i)
      2'b00: sel_pulse_w = pulse_r[0];
      2'b10: sel_pulse_w = pulse_r[1];
      2'b01: sel_pulse_w = pulse_r[2];
      2'b11: sel_pulse_w = pulse_r[3];
    endcase
  end

  // a select change can itself create one spurious edge
  wire sel_edge_w = sel_pulse_w != sel_prev_r;
  wire at_max_w = count_r == COUNT_MAX;
  wire conflict_w = sync2_r.gate && sync2_r.clr;

  always_comb begin
    count_nxt = count_r;
    if (sync2_r.clr) begin
      count_nxt = COUNT_RESET;
    end else if (sync2_r.gate && sel_edge_w && !at_max_w) begin
      count_nxt = count_r + 8'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= COUNT_RESET;
      sel_prev_r <= 1'b0;
      count_overflow_flag_r <= 1'b0;
      count_conflict_flag_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      sel_prev_r <= sel_pulse_w;
      // overflow and conflict, clear on read once gone
      count_overflow_flag_r <= at_max_w ||
                               (count_overflow_flag_r && !rd_cflag_w);
      count_conflict_flag_r <= conflict_w ||
                               (count_conflict_flag_r && !rd_cflag_w);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  wire diag_hit_w = reg_addr_i[7:3] == REG_DIAG_BASE[7:3];
  wire [1:0] diag_ch_w = reg_addr_i[2:1];

  always_comb begin
    rdata_nxt = 8'h00;
    if (diag_hit_w) begin
      rdata_nxt = reg_addr_i[0] ?
        {valid_bit_tally_w[diag_ch_w], 3'b000,
         diag_word_bits_w[diag_ch_w][8]} :
        diag_word_bits_w[diag_ch_w][7:0];
    end else begin
      unique case (reg_addr_i)
        REG_COUNT: rdata_nxt = count_r;
        REG_OD_FAULT: rdata_nxt = {4'h0, od_overcurrent_flag_r[1],
                                   od_short_flag_r[1],
                                   od_overcurrent_flag_r[0],
                                   od_short_flag_r[0]};
        REG_CNT_FLAGS: begin
          rdata_nxt[FLD_OVF] = count_overflow_flag_r;
          rdata_nxt[FLD_CONFLICT] = count_conflict_flag_r;
        end
        REG_NEW_FRAME: rdata_nxt = {4'h0, new_frame_flag_r};
        REG_STANDSTILL: rdata_nxt = {4'h0, standstill_flag_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= RDATA_RESET;
    end else if (reg_rd_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule

// ---- design/wsd_pkg.sv ----
package wsd_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int BIT_MIN_NS = 36000;
  localparam int BIT_MAX_NS = 64000;
  // least time rounds up, longest time rounds down
  localparam int BIT_MIN_CYC = (BIT_MIN_NS + CLK_PERIOD_NS - 1) /
                               CLK_PERIOD_NS;
  localparam int BIT_MAX_CYC = BIT_MAX_NS / CLK_PERIOD_NS;
  // boundary edges land at most half a slow bit after a centre
  localparam int CENTRE_MIN_CYC = BIT_MAX_CYC / 2 + 1;
  localparam int FRAME_GAP_CYC = 2 * BIT_MAX_CYC;
  localparam int TMR_W = 12;
  localparam int OD_DELAY_NS = 1000;
  localparam int OD_DELAY_CYC = OD_DELAY_NS / CLK_PERIOD_NS;
  localparam int OD_HOLD_NS = 100000;
  localparam int OD_HOLD_CYC = OD_HOLD_NS / CLK_PERIOD_NS;
  localparam int STILL_NS = 100000000;
  localparam int STILL_CYC = STILL_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_COUNT = 8'h04;
  localparam logic [7:0] REG_OD_FAULT = 8'h05;
  localparam logic [7:0] REG_CNT_FLAGS = 8'h06;
  localparam logic [7:0] REG_NEW_FRAME = 8'h07;
  localparam logic [7:0] REG_STANDSTILL = 8'h08;
  localparam logic [7:0] REG_DIAG_BASE = 8'h10;
  localparam int FLD_OVF = 0;
  localparam int FLD_CONFLICT = 1;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic SENSOR_INTELLIGENT = 1'b0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic over;
    logic high;
    logic diag;
    logic under;
  } wsd_class_t;

  typedef struct packed {
    logic [15:0] cmp;
    logic gate;
    logic clr;
    logic [1:0] od_short;
    logic [1:0] od_oc;
  } wsd_pins_t;

endpackage

// ---- design/wsd_manchester.sv ----
`timescale 1ns/1ps
module wsd_manchester
  import wsd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic level_i,
  output logic [8:0] word_o,
  output logic [3:0] tally_o,
  output logic frame_o
);

  typedef enum logic {DEC_IDLE, DEC_RUN} wsd_dec_t;

  wsd_dec_t state_r;
  logic prev_r;
  logic [TMR_W-1:0] timer_r;
  logic [8:0] bits_r;
  logic [3:0] idx_r;
  logic [3:0] tally_r;
  logic [8:0] word_r;
  logic frame_r;

  wire edge_w = level_i != prev_r;
  // boundary edges stay below this, even at the slowest legal bit
  wire accept_w = edge_w && (timer_r >= TMR_W'(CENTRE_MIN_CYC));
  wire valid_w = (timer_r >= TMR_W'(BIT_MIN_CYC)) &&
                 (timer_r <= TMR_W'(BIT_MAX_CYC));
  wire timeout_w = timer_r > TMR_W'(FRAME_GAP_CYC);
  wire tmr_sat_w = &timer_r;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= DEC_IDLE;
      prev_r <= 1'b0;
      timer_r <= '0;
      bits_r <= '0;
      idx_r <= 4'h0;
      tally_r <= 4'h0;
      word_r <= '0;
      frame_r <= 1'b0;
    end else begin
      prev_r <= level_i;
      frame_r <= 1'b0;
      if (edge_w && (state_r == DEC_IDLE || accept_w)) begin
        timer_r <= '0;
      end else if (!tmr_sat_w) begin
        timer_r <= timer_r + TMR_W'(1);
      end
      if (!en_i) begin
        state_r <= DEC_IDLE;
      end else begin
        unique case (state_r)
          DEC_IDLE: begin
            // frame start seen
            // only a rise leaves idle: the fall after a final one is no frame
            if (edge_w && level_i) begin
              state_r <= DEC_RUN;
              idx_r <= 4'h0;
              tally_r <= 4'h0;
              frame_r <= 1'b1;
            end
          end
          DEC_RUN: begin
            if (timeout_w) begin
              state_r <= DEC_IDLE;
            end else if (accept_w) begin
              bits_r <= {bits_r[7:0], level_i};
              idx_r <= idx_r + 4'h1;
              if (valid_w) begin
                tally_r <= tally_r + 4'h1;
              end
              if (idx_r == 4'h8) begin
                word_r <= {bits_r[7:0], level_i};
                state_r <= DEC_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  assign word_o = word_r;
  assign tally_o = tally_r;
  assign frame_o = frame_r;

endmodule

// ---- sim/wsd_sensor_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// sensor current seen through the comparator chain
// ----------------------------------------------------------------
module wsd_sensor_model
  import wsd_pkg::*;
(
  input wire logic [11:0] band_i,
  output logic [15:0] cmp_o
);
  // current crosses the thresholds in order, so the levels are a
  // thermometer code: band 0 is below level 1, band 4 above level 4
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      cmp_o[4*g +: 4] = 4'hF >> (3'd4 - band_i[3*g +: 3]);
    end
  end
endmodule

// ---- sim/wsd_core_assertions.sv ----
`timescale 1ns/1ps
module wsd_core_assertions
  import wsd_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] cmp_i,
  input wire logic [1:0] od_oc_i,
  input wire logic sensor_type_i,
  input wire logic [1:0] od_enable_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [NCH-1:0] speed_pulse_out_o,
  input wire logic [1:0] speed_open_drain_out_o,
  input wire logic [1:0] speed_open_drain_oe_o,
  input wire logic [NCH-1:0] overcurrent_o,
  input wire logic [NCH-1:0] undercurrent_o
);
  logic [2:0] up_r;
  logic [11:0] oc_r;
  wire [3:0] l1 = {cmp_i[12], cmp_i[8], cmp_i[4], cmp_i[0]};
  wire [3:0] l2 = {cmp_i[13], cmp_i[9], cmp_i[5], cmp_i[1]};
  wire [3:0] l3 = {cmp_i[14], cmp_i[10], cmp_i[6], cmp_i[2]};
  wire [3:0] l4 = {cmp_i[15], cmp_i[11], cmp_i[7], cmp_i[3]};
  wire up = (up_r == 3'h7);

  // up_r keeps $past away from values taken during reset
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) up_r <= 3'h0;
    else if (!up) up_r <= up_r + 3'h1;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) oc_r <= 12'h000;
    else if (!od_oc_i[0]) oc_r <= 12'h000;
    else if (oc_r != 12'hFFF) oc_r <= oc_r + 12'h001;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_intel;
    !sensor_type_i [*4] ##0 up;
  endsequence
  sequence s_active;
    sensor_type_i [*4] ##0 up;
  endsequence

  a_pulse_intel: assert property (s_intel |->
    speed_pulse_out_o == $past(l3, 3)) else $error("pulse intel");
  a_pulse_active: assert property (s_active |->
    speed_pulse_out_o == $past(l2, 3)) else $error("pulse active");
  a_over_intel: assert property (s_intel |->
    overcurrent_o == $past(l4, 3)) else $error("over intel");
  a_over_active: assert property (s_active |->
    overcurrent_o == $past(l3, 3)) else $error("over active");
  a_under_flag: assert property (up |->
    undercurrent_o == ~$past(l1, 3)) else $error("under flag");
  a_od_never_high: assert property (
    speed_open_drain_out_o == 2'h0) else $error("od high");
  a_od_follow: assert property ($rose(speed_open_drain_oe_o[0]) |->
    $past(speed_pulse_out_o[0], 26) && $past(od_enable_i[0]))
    else $error("od follow");
  a_od_off_en: assert property ((!od_enable_i[0]) [*3] |->
    !speed_open_drain_oe_o[0]) else $error("od enable");
  a_oc_disable: assert property (oc_r > 12'd2600 |->
    !speed_open_drain_oe_o[0]) else $error("oc disable");
  a_oc_hold_on: assert property (oc_r == 12'd2400 &&
    $past(speed_pulse_out_o[0], 26) && $past(od_enable_i[0]) |->
    speed_open_drain_oe_o[0]) else $error("oc hold");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 8'h30
    |=> reg_rdata_o == 8'h00) else $error("unmapped read");
endmodule

bind wsd_core wsd_core_assertions #(.NCH(NCH)) u_wsd_core_assertions (
  .mclk_i, .rst_n_i, .cmp_i, .od_oc_i, .sensor_type_i, .od_enable_i,
  .reg_rd_i, .reg_addr_i, .reg_rdata_o, .speed_pulse_out_o,
  .speed_open_drain_out_o, .speed_open_drain_oe_o, .overcurrent_o,
  .undercurrent_o
);

// ---- sim/wheel_speed_decoder_test.sv ----
`timescale 1ns/1ps
module wheel_speed_decoder_test
  import wsd_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] band = 12'h249;
  logic [15:0] cmp;
  logic gate = 1'b0, clr = 1'b0, stype = 1'b0, rd = 1'b0, den = 1'b0;
  logic [1:0] od_short = 2'h0, od_oc = 2'h0, sel = 2'h0, od_en = 2'h0;
  logic [7:0] addr = 8'h00, rdata, d;
  logic [3:0] spo, oc, uc;
  logic [1:0] odo, oe;
  int fails = 0;
  int checks_done = 0;
  // {type, band, pulse, over, under}
  localparam logic [6:0] ROWS [10] = '{7'h01, 7'h08, 7'h10, 7'h1C,
    7'h26, 7'h41, 7'h48, 7'h54, 7'h5E, 7'h66};

  always #20 mclk_i = ~mclk_i;

  wsd_sensor_model u_wsd_sensor_model (.band_i(band), .cmp_o(cmp));
  wsd_core #(.STILL_COUNT(200)) u_wsd_core (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmp_i(cmp),
    .count_gate_pin_i(gate), .count_clear_pin_i(clr),
    .od_short_i(od_short), .od_oc_i(od_oc), .sensor_type_i(stype),
    .diag_en_i(den), .counter_input_select_i(sel),
    .od_enable_i(od_en), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_rdata_o(rdata), .speed_pulse_out_o(spo),
    .speed_open_drain_out_o(odo), .speed_open_drain_oe_o(oe),
    .overcurrent_o(oc), .undercurrent_o(uc)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // read data stands after the taking edge; a spare cycle keeps rd
  // from being lowered and raised in one time step
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    rd = 1'b1;
    addr = a;
    cyc(1);
    rd = 1'b0;
    chk(rdata, exp);
    cyc(1);
  endtask
  task automatic tog(input int ch);
    band[3*ch +: 3] = (band[3*ch +: 3] == 3'd1) ? 3'd2 : 3'd1;
    cyc(4);
  endtask
  task automatic wait_oe(input logic [1:0] e);
    int i;
    for (i = 0; i < 100 && oe !== e; i++) cyc(1);
    if (i == 100) begin
      fails++;
      stop_test();
    end else begin
      chk({6'h00, oe}, {6'h00, e});
    end
  endtask
  // half a diagnostic cell on channel 1: high is the diagnostic band
  task automatic mhalf(input logic b, input int n);
    band[5:3] = b ? 3'h2 : 3'h1;
    cyc(n);
  endtask
  // rising start, then nine cells of 1000 cycles, first bit first;
  // the cell numbered late gets a stretched first half
  task automatic mframe(input logic [8:0] w, input int late);
    mhalf(1'b1, 500);
    for (int k = 8; k >= 0; k--) begin
      mhalf(!w[k], (k == late) ? 1200 : 500);
      mhalf(w[k], 500);
    end
    mhalf(1'b0, 500);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(20);
    rst_n_i = 1'b1;
    cyc(2);
    for (int r = 0; r < 10; r++) begin
      stype = ROWS[r][6];
      band = {4{ROWS[r][5:3]}};
      cyc(6);
      chk({4'h0, spo}, {4'h0, {4{ROWS[r][2]}}});
      chk({4'h0, oc}, {4'h0, {4{ROWS[r][1]}}});
      chk({4'h0, uc}, {4'h0, {4{ROWS[r][0]}}});
    end
    stype = 1'b1;
    band = 12'h249;
    for (int i = 0; i < 4; i++) begin
      sel = {i[0], i[1]};
      cyc(2);
      // clear with the gate low, so no conflict is raised
      gate = 1'b0;
      clr = 1'b1;
      cyc(4);
      clr = 1'b0;
      gate = 1'b1;
      cyc(4);
      tog(i);
      tog((i + 1) % 4);
      tog(i);
      rchk(REG_COUNT, 8'h02);
    end
    gate = 1'b0;
    tog(3);
    tog(3);
    rchk(REG_COUNT, 8'h02);
    rchk(REG_CNT_FLAGS, 8'h00);
    gate = 1'b1;
    clr = 1'b1;
    cyc(4);
    rchk(REG_COUNT, 8'h00);
    rchk(REG_CNT_FLAGS, 8'h02);
    clr = 1'b0;
    cyc(4);
    rchk(REG_CNT_FLAGS, 8'h02);
    rchk(REG_CNT_FLAGS, 8'h00);
    repeat (260) tog(3);
    rchk(REG_COUNT, COUNT_MAX);
    rchk(REG_CNT_FLAGS, 8'h01);
    gate = 1'b0;
    clr = 1'b1;
    cyc(4);
    clr = 1'b0;
    cyc(4);
    rchk(REG_CNT_FLAGS, 8'h01);
    rchk(REG_CNT_FLAGS, 8'h00);
    rchk(8'h30, 8'h00);
    stype = 1'b0;
    od_en = 2'h3;
    cyc(40);
    chk({6'h00, oe}, 8'h00);
    band[2:0] = 3'd3;
    wait_oe(2'h1);
    chk({6'h00, odo}, 8'h00);
    od_oc = 2'h1;
    od_short = 2'h2;
    cyc(2000);
    chk({6'h00, oe}, 8'h01);
    cyc(550);
    chk({6'h00, oe}, 8'h00);
    rchk(REG_OD_FAULT, 8'h06);
    od_oc = 2'h0;
    od_short = 2'h0;
    cyc(40);
    chk({6'h00, oe}, 8'h00);
    rchk(REG_OD_FAULT, 8'h06);
    rchk(REG_OD_FAULT, 8'h00);
    od_en = 2'h0;
    cyc(4);
    od_en = 2'h3;
    wait_oe(2'h1);
    band = 12'h249;
    cyc(300);
    den = 1'b1;
    cyc(2);
    mframe(9'h0A5, 9);
    rchk(8'h12, 8'hA5);
    rchk(8'h13, 8'h90);
    rchk(REG_NEW_FRAME, 8'h02);
    rchk(REG_NEW_FRAME, 8'h00);
    rchk(REG_STANDSTILL, 8'h02);
    rchk(REG_STANDSTILL, 8'h00);
    mframe(9'h0A5, 3);
    rchk(8'h13, 8'h80);
    rchk(8'h12, 8'hA5);
    rchk(REG_NEW_FRAME, 8'h02);
    stop_test();
  end
endmodule
